// file: hdl/pis_consts.vh
// Purpose: constants shared by the peripheral interrupt source block
// Assumes: 12 MHz core clock domain, synchronous active-low reset
// Notes: bit positions of the global interrupt enable byte and widths
`ifndef PIS_CONSTS_VH
`define PIS_CONSTS_VH
`define PIS_GIE_HUB_BIT 3
`define PIS_GIE_PIN_BIT 5
`define PIS_GIE_SBUS_BIT 6
`define PIS_GIE_ADDR 8'h20
`define PIS_HUB_PORTS 4
`define PIS_SINK_PINS 8
`define PIS_GP_PORTS 4
`define PIS_GP_WIDTH 32
`define PIS_GP_PORT_PINS 8
`define PIS_SYNC_RESET 2'h0
// Serial-bus engine states
`define PIS_SB_IDLE 3'h0
`define PIS_SB_XFER 3'h1
`define PIS_SB_WAIT 3'h2
`define PIS_SB_ARBW 3'h3
`define PIS_SB_STOP 3'h4
// Serial-bus modes
`define PIS_MD_SLV_RX 2'h0
`define PIS_MD_SLV_TX 2'h1
`define PIS_MD_MST_TX 2'h2
`define PIS_MD_MST_RX 2'h3
`endif

// file: hdl/pis_edge_lock.v
// Purpose: synchronised edge trigger group with shared lockout
// Assumes: pins asynchronous to clk, one polarity bit per pin
// Notes: one shared event output, lowest hitting pin owns the lockout
`timescale 1ns/1ps
`include "pis_consts.vh"
module pis_edge_lock #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire [WIDTH-1:0] pinIn,
    input wire [WIDTH-1:0] risingSel,
    input wire [WIDTH-1:0] pinEnable,
    input wire blockAll,
    output reg trigEvent,
    output reg [WIDTH-1:0] pinLevel
);
    reg [WIDTH-1:0] syncA_q; // First stage, read only by second
    reg [WIDTH-1:0] syncB_q; // Stable level
    reg [WIDTH-1:0] prev_q; // Previous stable level
    reg lockValid_q; // A pin holds the lockout
    reg [WIDTH-1:0] lockPin_q; // One-hot owner of the lockout
    wire [WIDTH-1:0] active; // Pin sits at its trigger level
    wire [WIDTH-1:0] edgeHit; // Qualifying edge per pin
    wire [WIDTH-1:0] firstHit; // Lowest hit, only chosen to own lock
    wire lockRelease;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gPin
            // Trigger level follows the pin's own polarity
            assign active[i] = risingSel[i] ? syncB_q[i] : ~syncB_q[i];
            assign edgeHit[i] = pinEnable[i] & active[i] & (syncB_q[i] ^ prev_q[i]);
        end
    endgenerate

    assign firstHit = edgeHit & (~edgeHit + {{(WIDTH-1){1'b0}}, 1'b1});
    // Lock ends when owner leaves trigger level or is disabled
    assign lockRelease = ~|(lockPin_q & active & pinEnable);

    // Synchroniser and edge history
    always @(posedge clk) begin
        if (!reset_n) begin
            // History starts at pin level, so release gives no false edge
            syncA_q <= pinIn;
            syncB_q <= pinIn;
            prev_q <= pinIn;
        end else begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
            prev_q <= syncB_q;
        end
    end

    // Lockout and single shared event
    always @(posedge clk) begin
        if (!reset_n) begin
            lockValid_q <= 1'b0;
            lockPin_q <= {WIDTH{1'b0}};
            trigEvent <= 1'b0;
            pinLevel <= {WIDTH{1'b0}};
        end else begin
            pinLevel <= syncB_q;
            trigEvent <= 1'b0;
            if (lockValid_q && !lockRelease) begin
                lockValid_q <= 1'b1; // Other pins blocked meanwhile
            end else if (|edgeHit && !blockAll) begin
                lockValid_q <= 1'b1;
                lockPin_q <= firstHit;
                trigEvent <= 1'b1;
            end else begin
                lockValid_q <= 1'b0;
                lockPin_q <= {WIDTH{1'b0}};
            end
        end
    end
endmodule // pis_edge_lock

// file: hdl/pis_sbus_fsm.v
// Purpose: serial-bus interrupt sequencing for slave, master, arbitration
// Assumes: bus engine reports byte, start, stop and arbitration events
// Notes: raises one-cycle event once status bits are settled
`timescale 1ns/1ps
`include "pis_consts.vh"
module pis_sbus_fsm (
    input wire clk,
    input wire reset_n,
    input wire [1:0] mode,
    input wire byteDone,
    input wire startSeen,
    input wire stopSeen,
    input wire arbLost,
    input wire ackIn,
    input wire continueSet,
    input wire masterModeWrite,
    input wire masterModeIn,
    output reg sbEvent,
    output reg continueBusy,
    output reg masterModeBit,
    output reg arbitrationLostFlag,
    output reg addrMatchFlag,
    output reg rxStopFlag,
    output reg ackFlag,
    output reg issueStop
);
    reg [2:0] state_q;
    reg firstByte_q; // Next byte follows a start
    reg lastNak_q; // Previous slave-rx byte was not acknowledged

    // Bus engine sequencing; flags settle before event pulses
    always @(posedge clk) begin
        if (!reset_n) begin
            state_q <= `PIS_SB_IDLE;
            firstByte_q <= 1'b0;
            lastNak_q <= 1'b0;
            sbEvent <= 1'b0;
            continueBusy <= 1'b0;
            masterModeBit <= 1'b0;
            arbitrationLostFlag <= 1'b0;
            addrMatchFlag <= 1'b0;
            rxStopFlag <= 1'b0;
            ackFlag <= 1'b0;
            issueStop <= 1'b0;
        end else begin
            sbEvent <= 1'b0;
            issueStop <= 1'b0;
            if (masterModeWrite) begin
                masterModeBit <= masterModeIn;
            end
            if (startSeen) begin
                firstByte_q <= 1'b1;
            end
            case (state_q)
                `PIS_SB_IDLE, `PIS_SB_XFER: begin
                    if (continueSet) begin
                        continueBusy <= 1'b1; // Firmware starts transfer
                        state_q <= `PIS_SB_XFER;
                        // Master with mode cleared ends the transfer
                        if (mode[1] && masterModeWrite && !masterModeIn) begin
                            issueStop <= 1'b1;
                            continueBusy <= 1'b0;
                            state_q <= `PIS_SB_IDLE;
                        end
                    end else if (arbLost && mode[1]) begin
                        masterModeBit <= 1'b0;
                        arbitrationLostFlag <= 1'b1;
                        state_q <= `PIS_SB_ARBW;
                    end else if (byteDone) begin
                        continueBusy <= 1'b0;
                        state_q <= `PIS_SB_WAIT;
                        case (mode)
                            `PIS_MD_SLV_RX: begin
                                addrMatchFlag <= firstByte_q;
                                firstByte_q <= 1'b0;
                                lastNak_q <= ~ackIn;
                            end
                            `PIS_MD_SLV_TX: ackFlag <= ackIn;
                            default: ackFlag <= ackIn;
                        endcase
                    end else if (stopSeen && mode == `PIS_MD_SLV_RX && !lastNak_q) begin
                        rxStopFlag <= 1'b1;
                        state_q <= `PIS_SB_STOP;
                    end
                end
                `PIS_SB_WAIT, `PIS_SB_STOP: begin
                    sbEvent <= 1'b1; // one cycle after flags
                    state_q <= `PIS_SB_IDLE;
                end
                `PIS_SB_ARBW: begin
                    if (stopSeen) begin
                        sbEvent <= 1'b1;
                        state_q <= `PIS_SB_IDLE;
                    end
                end
                default: state_q <= `PIS_SB_IDLE;
            endcase
        end
    end
endmodule // pis_sbus_fsm

// file: hdl/pis_int_sources.v
// Purpose: peripheral interrupt requests for hub, sink pins, pins, serial bus
// Assumes: single 12 MHz clock, acknowledge pulses from the core
// Notes: each source has its own pending flop, gated by its enable except sink
`timescale 1ns/1ps
`include "pis_consts.vh"
module pis_int_sources (
    clk,
    reset_n,
    globalIntEnable,
    hubConnectChange,
    hubBabble,
    hubResume,
    hubPortEnable,
    hubPortForced,
    hubAck,
    sinkPins,
    sinkRising,
    sinkEnable,
    sinkAck,
    gpPins,
    gpPortRising,
    gpPinEnable,
    parallelHostPortEn,
    parallelHostEvent,
    pinAck,
    sbMode,
    sbByteDone,
    sbStartSeen,
    sbStopSeen,
    sbArbLost,
    sbAckIn,
    sbContinueSet,
    sbMasterModeWrite,
    sbMasterModeIn,
    sbAck,
    hubIrq,
    sinkIrq,
    pinIrq,
    sbIrq,
    sinkLevel,
    gpLevel,
    continueBusy,
    masterModeBit,
    arbitrationLostFlag,
    addrMatchFlag,
    rxStopFlag,
    ackFlag,
    sbIssueStop
);
    // Clock and synchronous reset
    input wire clk;
    input wire reset_n;
    // Global enables; three bits used here
    input wire [7:0] globalIntEnable; // Global enable byte

    // Hub repeater events, one bit per port
    input wire [`PIS_HUB_PORTS-1:0] hubConnectChange; // Repeater pulses
    input wire [`PIS_HUB_PORTS-1:0] hubBabble;
    input wire [`PIS_HUB_PORTS-1:0] hubResume;
    input wire [`PIS_HUB_PORTS-1:0] hubPortEnable;
    input wire [`PIS_HUB_PORTS-1:0] hubPortForced; // Firmware forces port
    input wire hubAck; // Core services hub vector

    // Current-sink pins, polarity per pin
    input wire [`PIS_SINK_PINS-1:0] sinkPins;
    input wire [`PIS_SINK_PINS-1:0] sinkRising;
    input wire [`PIS_SINK_PINS-1:0] sinkEnable;
    input wire sinkAck;

    // General-purpose pins, polarity per port
    input wire [`PIS_GP_WIDTH-1:0] gpPins;
    input wire [`PIS_GP_PORTS-1:0] gpPortRising; // One polarity per port
    input wire [`PIS_GP_WIDTH-1:0] gpPinEnable;

    // Parallel port takes the pin vector
    input wire parallelHostPortEn;
    input wire parallelHostEvent; // Parallel port event pulse
    input wire pinAck;

    // Serial-bus engine reports, firmware writes
    input wire [1:0] sbMode;
    input wire sbByteDone;
    input wire sbStartSeen;
    input wire sbStopSeen;
    input wire sbArbLost;
    input wire sbAckIn;
    input wire sbContinueSet;
    input wire sbMasterModeWrite;
    input wire sbMasterModeIn;
    input wire sbAck;

    // Requests: pending flop AND enable, sink flop alone
    output wire hubIrq;
    output wire sinkIrq;
    output wire pinIrq;
    output wire sbIrq;

    // Levels so firmware finds the causing pins
    output wire [`PIS_SINK_PINS-1:0] sinkLevel;
    output wire [`PIS_GP_WIDTH-1:0] gpLevel;

    // Serial-bus status, settled before request
    output wire continueBusy;
    output wire masterModeBit;
    output wire arbitrationLostFlag;
    output wire addrMatchFlag;
    output wire rxStopFlag;
    output wire ackFlag;
    output wire sbIssueStop;

    // Timing, in core clock edges:
    // Hub and parallel port events are
    // synchronous already. The pending flop
    // sets on the next edge, the request
    // follows at once.
    // A pin change passes two synchroniser
    // stages and one edge stage, so its
    // pending flop sets on the fourth edge.
    // A serial-bus byte moves the status
    // bits first. The event follows one edge
    // later and the pending flop one after
    // that, so the core never sees a request
    // while the bits are still moving.
    // Arbitration loss moves its bits at
    // once but holds the request back until
    // the bus shows a stop.
    //
    // Acknowledge clears only the pending
    // flop of the serviced source. Enables
    // are inputs and never written here, so
    // service cannot disturb any set-up.
    //
    // Limitation: a pin already at its
    // trigger level when enabled does not
    // request; only a fresh edge does.
    // Firmware should read the level output
    // after enabling to catch that case.
    //
    // Reset clears pending flops, lockouts
    // and the serial-bus sequencer. Pin
    // history loads from the pins during
    // reset, so a pin resting at its trigger
    // level is no edge at release.
    //
    // Trade-off: requests other than sink are
    // plain ANDs of flop and enable. Enabling a
    // masked source requests at once, at the
    // cost of a short path from the enable
    // register to the core.

    reg hubPend_q; // Pending flops, one per source
    reg sinkPend_q;
    reg pinPend_q;
    reg sbPend_q;
    wire hubEvent;
    wire sinkEvent;
    wire gpEvent;
    wire sbEvent;
    wire pinEvent;
    wire [`PIS_GP_WIDTH-1:0] gpRising; // Port polarity spread per pin

    // Group module wants one polarity per pin,
    // so each port bit is spread over its pins
    genvar p;
    generate
        for (p = 0; p < `PIS_GP_WIDTH; p = p + 1) begin : gPol
            assign gpRising[p] = gpPortRising[p / `PIS_GP_PORT_PINS];
        end
    endgenerate

    // Hub: connect changes only from unforced ports
    wire [`PIS_HUB_PORTS-1:0] hubConnQual; // Change on an unforced port
    wire [`PIS_HUB_PORTS-1:0] hubLineQual; // Babble or resume, enabled port
    genvar h;
    generate
        for (h = 0; h < `PIS_HUB_PORTS; h = h + 1) begin : gHub
            // Forced port: line state is firmware's own
            assign hubConnQual[h] = hubConnectChange[h] & ~hubPortForced[h];
            // Disabled port traffic is not reported
            assign hubLineQual[h] = (hubBabble[h] | hubResume[h]) & hubPortEnable[h];
        end
    endgenerate
    assign hubEvent = |hubConnQual | |hubLineQual;

    // Sink pins: no global gate bit exists,
    // so only the per-pin enables mute them.
    // Nothing else shares this vector.
    pis_edge_lock #(.WIDTH(`PIS_SINK_PINS)) uSink (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(sinkPins),
        .risingSel(sinkRising),
        .pinEnable(sinkEnable),
        .blockAll(1'b0),
        .trigEvent(sinkEvent),
        .pinLevel(sinkLevel)
    );

    // General-purpose pins: the lockout keeps
    // a second pin quiet until the first has
    // gone back or been disabled.
    // Parallel port blocks every GP pin while enabled
    pis_edge_lock #(.WIDTH(`PIS_GP_WIDTH)) uGpio (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(gpPins),
        .risingSel(gpRising),
        .pinEnable(gpPinEnable),
        .blockAll(parallelHostPortEn),
        .trigEvent(gpEvent),
        .pinLevel(gpLevel)
    );

    // Blocked pin edges are dropped, not kept,
    // so none fires late when the parallel
    // port is switched off again.
    // Shared pin vector owned by parallel port when enabled
    assign pinEvent = parallelHostPortEn ? parallelHostEvent : gpEvent;

    // Serial bus: firmware writes come in as
    // strobes. Mode upper bit marks master
    // modes, which alone react to lost
    // arbitration and a cleared mode bit.
    pis_sbus_fsm uSbus (
        .clk(clk),
        .reset_n(reset_n),
        .mode(sbMode),
        .byteDone(sbByteDone),
        .startSeen(sbStartSeen),
        .stopSeen(sbStopSeen),
        .arbLost(sbArbLost),
        .ackIn(sbAckIn),
        .continueSet(sbContinueSet), // one write per interrupt expected
        .masterModeWrite(sbMasterModeWrite),
        .masterModeIn(sbMasterModeIn),
        .sbEvent(sbEvent),
        .continueBusy(continueBusy),
        .masterModeBit(masterModeBit),
        .arbitrationLostFlag(arbitrationLostFlag),
        .addrMatchFlag(addrMatchFlag),
        .rxStopFlag(rxStopFlag),
        .ackFlag(ackFlag),
        .issueStop(sbIssueStop)
    );

    // Pending flops; a new event wins over acknowledge in same cycle
    // Losing an event is worse than one extra
    // service call; causes are read back.
    always @(posedge clk) begin
        if (!reset_n) begin
            hubPend_q <= 1'b0;
            sinkPend_q <= 1'b0;
            pinPend_q <= 1'b0;
            sbPend_q <= 1'b0;
        end else begin
            hubPend_q <= hubEvent | (hubPend_q & ~hubAck);
            sinkPend_q <= sinkEvent | (sinkPend_q & ~sinkAck);
            pinPend_q <= pinEvent | (pinPend_q & ~pinAck);
            sbPend_q <= sbEvent | (sbPend_q & ~sbAck);
        end
    end

    // Requests only while enabled; enables untouched by acknowledge
    // A flop keeps its state while masked, so
    // a source that fired meanwhile requests
    // as soon as its enable returns.
    assign hubIrq = hubPend_q & globalIntEnable[`PIS_GIE_HUB_BIT];
    assign pinIrq = pinPend_q & globalIntEnable[`PIS_GIE_PIN_BIT];
    assign sbIrq = sbPend_q & globalIntEnable[`PIS_GIE_SBUS_BIT];
    // Sink enable byte keeps its own gating; no global bit given
    assign sinkIrq = sinkPend_q;
endmodule // pis_int_sources

// file: verification/pis_core_model.sv
// Purpose: core side model that services raised interrupt requests
// Assumes: one acknowledge pulse per serviced vector
// Notes: latency is set by the bench, zero for prompt service
`timescale 1ns/1ps
module pis_core_model (
    input wire clk,
    input wire reset_n,
    input wire [3:0] irqLines,
    input wire [3:0] ackDelay,
    output reg [3:0] ackPulse = 4'h0
);
    reg [3:0] waitCnt_q [0:3]; // Cycles each request has stood
    integer i;
    // Acknowledge touches only the pending flop, never any enable
    always @(posedge clk) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (!reset_n || !irqLines[i] || ackPulse[i]) begin
                waitCnt_q[i] <= 4'h0;
                ackPulse[i] <= 1'b0;
            end else if (waitCnt_q[i] >= ackDelay) begin
                ackPulse[i] <= 1'b1; // Service clears pending
            end else begin
                waitCnt_q[i] <= waitCnt_q[i] + 4'h1;
            end
        end
    end
endmodule // pis_core_model

// file: verification/pis_int_sources_properties.sv
// Purpose: port-level assertions for the interrupt source block
// Assumes: synchronous active-low reset, one clock
// Notes: request latency windows follow the hand-over timing
`timescale 1ns/1ps
module pis_int_sources_properties (
    input wire clk,
    input wire reset_n,
    input wire [7:0] globalIntEnable,
    input wire [3:0] hubConnectChange,
    input wire [3:0] hubPortForced,
    input wire hubAck,
    input wire [1:0] sbMode,
    input wire sbByteDone,
    input wire sbStopSeen,
    input wire sbArbLost,
    input wire sbAckIn,
    input wire hubIrq,
    input wire pinIrq,
    input wire sbIrq,
    input wire continueBusy,
    input wire masterModeBit,
    input wire arbitrationLostFlag,
    input wire ackFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Lost arbitration while no serial request stands
    sequence arbLoss;
        sbArbLost && sbMode[1] && !sbIrq;
    endsequence
    // No stop and no byte for three cycles
    sequence quietBus;
        (!sbStopSeen && !sbByteDone) [*3];
    endsequence
    hub_raise_a: assert property ((|(hubConnectChange & ~hubPortForced)) && globalIntEnable[3]
        |-> ##[1:3] hubIrq) else $error("hub request missing");
    hub_gate_a: assert property (!globalIntEnable[3] |-> !hubIrq) else $error("hub ungated");
    pin_gate_a: assert property (!globalIntEnable[5] |-> !pinIrq) else $error("pin ungated");
    sbus_gate_a: assert property (!globalIntEnable[6] |-> !sbIrq) else $error("bus ungated");
    pending_hold_a: assert property (hubIrq && !hubAck && globalIntEnable[3]
        |=> hubIrq || !globalIntEnable[3]) else $error("hub pending lost");
    busy_clear_a: assert property (sbByteDone |=> !continueBusy)
        else $error("busy not cleared");
    ack_flag_a: assert property (sbByteDone && sbMode == 2'h1 |=> ackFlag == $past(sbAckIn))
        else $error("ack flag wrong");
    arb_clear_a: assert property (sbArbLost && sbMode[1]
        |=> !masterModeBit && arbitrationLostFlag) else $error("arbitration flags");
    arb_wait_a: assert property (arbLoss ##1 quietBus |-> !sbIrq)
        else $error("early arbitration request");
endmodule // pis_int_sources_properties
bind pis_int_sources pis_int_sources_properties pis_int_sources_properties_inst (.clk, .reset_n,
    .globalIntEnable, .hubConnectChange, .hubPortForced, .hubAck, .sbMode, .sbByteDone,
    .sbStopSeen, .sbArbLost, .sbAckIn, .hubIrq, .pinIrq, .sbIrq, .continueBusy,
    .masterModeBit, .arbitrationLostFlag, .ackFlag);

// file: verification/testbench.sv
// Purpose: self-checking bench for the interrupt source block
// Assumes: core model acknowledges raised requests
// Notes: driver queues expected request vectors, monitor matches rises
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg [7:0] gie = 8'h68; // Hub, pin and serial enables
    reg [3:0] hubCc = 4'h0;
    reg [3:0] hubBab = 4'h0;
    reg [3:0] hubRes = 4'h0;
    reg [3:0] hubEn = 4'h0;
    reg [3:0] hubFrc = 4'h0;
    reg [3:0] sel = 4'h0;
    reg [7:0] sinkP = 8'h00;
    reg [7:0] sinkR = 8'h00;
    reg [7:0] sinkE = 8'h00;
    reg [31:0] gpP = 32'h0;
    reg [31:0] gpE = 32'hFFFFFFFF;
    reg [3:0] gpR = 4'hF;
    reg hpEn = 1'b0;
    reg hpEv = 1'b0;
    reg [1:0] md = 2'h0;
    reg [3:0] sbEv = 4'h0; // Byte, start, stop, arbitration pulses
    reg sbAk = 1'b1;
    reg sbCs = 1'b0;
    reg sbMw = 1'b0;
    reg sbMi = 1'b0;
    reg [3:0] ackDly = 4'h0;
    reg [3:0] irqLast = 4'h0;
    reg issSeen = 1'b0;
    wire [3:0] ack;
    wire [3:0] irqNow;
    wire [7:0] sinkLevel;
    wire [31:0] gpLevel;
    wire busy, mmb, alf, amf, rsf, akf, iss;
    logic [3:0] notes[$]; // Expected request vectors, oldest first
    integer nErrors = 0;
    integer checkCount = 0;
    integer pol, k, j, p, a;
    pis_int_sources pis_int_sources_inst (.clk(clk), .reset_n(reset_n), .globalIntEnable(gie),
        .hubConnectChange(hubCc), .hubBabble(hubBab), .hubResume(hubRes), .hubPortEnable(hubEn),
        .hubPortForced(hubFrc), .hubAck(ack[3]), .sinkPins(sinkP), .sinkRising(sinkR),
        .sinkEnable(sinkE), .sinkAck(ack[2]), .gpPins(gpP), .gpPortRising(gpR),
        .gpPinEnable(gpE), .parallelHostPortEn(hpEn), .parallelHostEvent(hpEv),
        .pinAck(ack[1]), .sbMode(md), .sbByteDone(sbEv[3]), .sbStartSeen(sbEv[2]),
        .sbStopSeen(sbEv[1]), .sbArbLost(sbEv[0]), .sbAckIn(sbAk), .sbContinueSet(sbCs),
        .sbMasterModeWrite(sbMw), .sbMasterModeIn(sbMi), .sbAck(ack[0]), .hubIrq(irqNow[3]),
        .sinkIrq(irqNow[2]), .pinIrq(irqNow[1]), .sbIrq(irqNow[0]), .sinkLevel(sinkLevel),
        .gpLevel(gpLevel), .continueBusy(busy), .masterModeBit(mmb),
        .arbitrationLostFlag(alf), .addrMatchFlag(amf), .rxStopFlag(rsf), .ackFlag(akf),
        .sbIssueStop(iss));
    pis_core_model pis_core_model_inst (.clk(clk), .reset_n(reset_n), .irqLines(irqNow),
        .ackDelay(ackDly), .ackPulse(ack));
    always #2 clk = ~clk;
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount = checkCount + 1;
        if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Queue a vector, wait bounded for the monitor to take it
    task expectIrq(input logic [3:0] v);
        integer n;
        notes.push_back(v);
        n = 0;
        while (notes.size() != 0 && n < 40) begin
            tick(1);
            n = n + 1;
        end
        if (notes.size() != 0) begin
            check("request arrival", v, 4'h0);
            notes.delete();
        end
        tick(14);
    endtask
    // Any rise here is flagged by the monitor
    task quiet;
        tick(14);
        check("idle requests", 4'h0, irqNow);
    endtask
    task sbPulse(input [3:0] v);
        sbEv = v;
        tick(1);
        sbEv = 4'h0;
        tick(1); // Idle edge keeps back-to-back pulses apart
    endtask
    task hubPulse(input [11:0] v);
        {hubCc, hubBab, hubRes} = v;
        tick(1);
        {hubCc, hubBab, hubRes} = 12'h0;
    endtask
    // One control write: mode bit plus continue
    task sbWrite(input v);
        sbMi = v;
        sbMw = 1'b1;
        sbCs = 1'b1; // Single write after each master interrupt
        tick(1);
        sbMw = 1'b0;
        sbCs = 1'b0;
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Match each rising request against the oldest note
    always @(posedge clk) begin
        irqLast <= irqNow;
        if (iss) issSeen <= 1'b1;
        if (reset_n && (irqNow & ~irqLast) != 4'h0) begin
            if (notes.size() == 0) check("request rise", 4'h0, irqNow);
            else check("request rise", notes.pop_front(), irqNow);
        end
    end
    initial begin
        #40000;
        nErrors = nErrors + 1;
        report_and_stop;
    end
    initial begin
        a = $urandom(76);
        tick(10);
        reset_n = 1'b1;
        tick(3);
        p = $urandom % 4;
        sel = 4'h1 << p;
        hubPulse({sel, 8'h00});
        expectIrq(4'h8);
        hubFrc = sel;
        hubPulse({sel, 8'h00});
        quiet;
        hubFrc = 4'h0;
        hubPulse({4'h0, sel, 4'h0});
        quiet;
        hubEn = sel;
        ackDly = 4'h5;
        hubPulse({4'h0, sel, 4'h0});
        expectIrq(4'h8);
        hubPulse({8'h00, sel});
        expectIrq(4'h8);
        gie = 8'h20;
        hubPulse({sel, 8'h00});
        quiet;
        gie = 8'h68;
        expectIrq(4'h8);
        k = $urandom % 8;
        j = (k + 1 + $urandom % 7) % 8;
        for (pol = 1; pol >= 0; pol = pol - 1) begin
            sinkR = {8{pol[0]}};
            sinkP = {8{~pol[0]}};
            sinkE = 8'h00;
            tick(8);
            sinkE = 8'hFF;
            sinkP[k] = pol[0];
            expectIrq(4'h4);
            check("sink level", pol[0], sinkLevel[k]);
            sinkP[j] = pol[0];
            quiet;
            sinkP[k] = ~pol[0];
            tick(6);
            sinkP[j] = ~pol[0];
            tick(6);
            sinkP[j] = pol[0];
            expectIrq(4'h4);
        end
        p = $urandom % 4;
        k = 8 * p + $urandom % 8;
        gpP[k] = 1'b1;
        expectIrq(4'h2);
        check("pin level", 1, gpLevel[k]);
        gpR[p] = 1'b0;
        gpP[k] = 1'b0;
        expectIrq(4'h2);
        hpEn = 1'b1;
        gpP[k] = 1'b1;
        tick(6);
        gpP[k] = 1'b0;
        quiet;
        gpE = 32'h0;
        hpEv = 1'b1;
        tick(1);
        hpEv = 1'b0;
        expectIrq(4'h2);
        gie[5] = 1'b0;
        hpEv = 1'b1;
        tick(1);
        hpEv = 1'b0;
        quiet;
        gie[5] = 1'b1;
        expectIrq(4'h2);
        hpEn = 1'b0;
        sbPulse(4'h4);
        sbPulse(4'h8);
        expectIrq(4'h1);
        check("address flag", 1, amf);
        check("busy bit", 0, busy);
        sbPulse(4'h8);
        expectIrq(4'h1);
        check("address flag", 0, amf);
        sbPulse(4'h2);
        expectIrq(4'h1);
        check("stop flag", 1, rsf);
        sbAk = 1'b0;
        sbPulse(4'h8);
        expectIrq(4'h1);
        sbPulse(4'h2);
        quiet;
        md = 2'h1;
        for (a = 0; a < 2; a = a + 1) begin
            sbAk = a[0];
            sbPulse(4'h8);
            expectIrq(4'h1);
            check("ack flag", a[0], akf);
        end
        for (a = 2; a < 4; a = a + 1) begin
            md = a[1:0];
            sbWrite(1'b1);
            check("busy bit", 1, busy);
            sbPulse(4'h8);
            expectIrq(4'h1);
            issSeen = 1'b0;
            sbWrite(1'b0);
            quiet;
            check("stop issued", 1, issSeen);
            check("master mode", 0, mmb);
        end
        md = 2'h2;
        sbWrite(1'b1);
        sbPulse(4'h1);
        tick(1);
        check("master mode", 0, mmb);
        check("arbitration flag", 1, alf);
        quiet;
        sbPulse(4'h2);
        expectIrq(4'h1);
        report_and_stop;
    end
endmodule // testbench
